// ===== scs_config_regs.v
// Supply configuration registers with EEPROM power-up load and the
// control logic they steer: soft-start, fault latch/restart, polarity.
// Assumes an SMBus engine on clk_in presenting decoded register cycles,
// and an EEPROM shadow reader answering one byte per request.
`timescale 1ns/100ps
`include "scs_defines.vh"

// Functional notes
// - Share capture threshold 1..4 percent from field
// - Soft-start rise time from bits 3..2
// - Bit 1 is second SMBus address bit
// - Lock set blocks writes to trim registers
// - Current-limit disable masks overcurrent, flag stays
// - Bit 6 selects power-enable polarity, with partner
// - Bit 5 selects breaker polarity, with partner
// - Zero ridethrough bit, else period from field
// - Bit 1 disconnects ground-ok from power management
// - Bit 0 selects breaker latching or nonlatching
// - Restart mode retries start every second
// - Latch mode holds off until supply-on cycles
// - Bit 6 selects raw or host-gated AC path
// - Write-only bit 5 drives AC-sense-ok directly
// - Fault register loads from EEPROM at power-up
// - Restart register loads from EEPROM at power-up
// - Soft-start register loads from EEPROM at power-up
module scs_config_regs #(
    parameter US_CYCLES     = `SCS_US_CYCLES,
    parameter SS_T0_TICKS   = `SCS_SS_T0_TICKS,
    parameter SS_T1_TICKS   = `SCS_SS_T1_TICKS,
    parameter SS_T2_TICKS   = `SCS_SS_T2_TICKS,
    parameter SS_T3_TICKS   = `SCS_SS_T3_TICKS,
    parameter RETRY_TICKS   = `SCS_RETRY_TICKS,
    parameter RT_STEP_TICKS = `SCS_RT_STEP_US,
    parameter RT_RESID_TICKS = `SCS_RT_RESID_US
) (
    input  wire       clk_in,                 // System clock, 100 MHz
    input  wire       reset_n_in,             // Synchronous reset, active low
    input  wire       reg_wr_in,              // Register write strobe
    input  wire       reg_rd_in,              // Register read strobe
    input  wire [7:0] reg_addr_in,            // Register offset
    input  wire [7:0] reg_wdata_in,           // Write data
    output reg  [7:0] reg_rdata_out,          // Read data, valid after strobe
    output reg        reg_ack_out,            // Access done pulse
    output reg        ee_rd_req_out,          // EEPROM read request pulse
    output reg [15:0] ee_addr_out,            // EEPROM location
    input  wire       ee_valid_in,            // EEPROM data valid pulse
    input  wire [7:0] ee_data_in,             // EEPROM data
    input  wire       test_download_in,       // Reload shadows pulse
    output reg        load_done_out,          // Shadow copy complete
    input  wire       supply_on_req_in,       // Supply-on request pin
    input  wire       ac_ok_raw_in,           // Raw AC-ok pin
    input  wire       gnd_ok_in,              // Ground continuity pin
    input  wire       overcurrent_in,         // Overcurrent comparator
    input  wire       undervoltage_in,        // Undervoltage comparator
    input  wire       power_enable_pol_hi_in, // Partner POWER_ENABLE_OUT polarity bit
    input  wire       breaker_pol_hi_in,      // Partner breaker polarity bit
    input  wire [1:0] ridethrough_sel_in,     // Ridethrough field
    input  wire       breaker_clear_in,       // Breaker latch clear pulse
    output reg  [2:0] share_capture_pct_out,  // Share threshold, percent
    output reg        second_addr_bit_out,    // SMBus address bit
    output reg        trim_lock_out,          // Trim write lock
    output reg        soft_start_active_out,  // Soft-start ramp running
    output reg        power_enable_out,       // Power-enable pin
    output reg        breaker_out,            // Circuit-breaker pin
    output reg        oc_flag_out,            // Overcurrent status flag
    output reg        fault_latched_out,      // Output latched off
    output reg        ac_sense_ok_out         // AC-sense-ok signal
);
    localparam ST_OFF   = 3'h0;
    localparam ST_SOFT  = 3'h1;
    localparam ST_ON    = 3'h2;
    localparam ST_LATCH = 3'h3;
    localparam ST_RETRY = 3'h4;

    localparam LD_IDLE = 2'h0;
    localparam LD_REQ  = 2'h1;
    localparam LD_WAIT = 2'h2;

    reg  [7:0]  ss_reg_q;
    reg  [7:0]  fault_reg_q;
    reg  [7:0]  restart_reg_q;
    reg  [1:0]  ld_state_q;
    reg  [1:0]  ld_idx_q;
    reg  [2:0]  st_q;
    reg  [2:0]  st_d;
    reg  [19:0] tmr_q;
    reg  [19:0] rt_cnt_q;
    reg  [4:0]  sync1_q;
    reg  [4:0]  sync2_q;
    reg         brk_hold_q;
    wire        us_tick;
    wire        son_s;
    wire        ac_s;
    wire        gnd_s;
    wire        oc_s;
    wire        uv_s;
    wire        pm_ok;
    wire        oc_eff;
    wire        fault;
    wire        wr_ok;
    wire [19:0] ss_ticks;
    wire [19:0] rt_ticks;
    wire        pen_inv;
    wire        brk_inv;
    wire        brk_raw;

    function [15:0] ee_loc;
        input [1:0] idx;
        begin
            case (idx)
                2'h0:    ee_loc = `SCS_EE_SOFTSTART;
                2'h1:    ee_loc = `SCS_EE_FAULT;
                default: ee_loc = `SCS_EE_RESTART;
            endcase
        end
    endfunction

    scs_tick_div #(
        .DIV        (US_CYCLES)
    ) u_us_div (
        .clk_in     (clk_in),
        .reset_n_in (reset_n_in),
        .tick_out   (us_tick)
    );

    // Pin synchronisers
    always @(posedge clk_in) begin
        if (!reset_n_in) begin
            sync1_q <= 5'h00;
            sync2_q <= 5'h00;
        end else begin
            sync1_q <= {supply_on_req_in, ac_ok_raw_in, gnd_ok_in,
                        overcurrent_in, undervoltage_in};
            sync2_q <= sync1_q;
        end
    end
    assign son_s = sync2_q[4];
    assign ac_s  = sync2_q[3];
    assign gnd_s = sync2_q[2];
    assign oc_s  = sync2_q[1];
    assign uv_s  = sync2_q[0];

    // EEPROM shadow copy after reset or test download
    always @(posedge clk_in) begin
        if (!reset_n_in) begin
            ld_state_q    <= LD_REQ;
            ld_idx_q      <= 2'h0;
            ee_rd_req_out <= 1'b0;
            ee_addr_out   <= 16'h0000;
            load_done_out <= 1'b0;
        end else begin
            ee_rd_req_out <= 1'b0;
            case (ld_state_q)
                LD_IDLE: begin
                    if (test_download_in) begin
                        ld_state_q    <= LD_REQ;
                        ld_idx_q      <= 2'h0;
                        load_done_out <= 1'b0;
                    end
                end
                LD_REQ: begin
                    ee_rd_req_out <= 1'b1;
                    ee_addr_out   <= ee_loc(ld_idx_q);
                    ld_state_q    <= LD_WAIT;
                end
                LD_WAIT: begin
                    if (ee_valid_in) begin
                        if (ld_idx_q == 2'h2) begin
                            ld_state_q    <= LD_IDLE;
                            load_done_out <= 1'b1;
                        end else begin
                            ld_idx_q   <= ld_idx_q + 2'h1;
                            ld_state_q <= LD_REQ;
                        end
                    end
                end
                default: ld_state_q <= LD_IDLE;
            endcase
        end
    end

    // Lock covers every trim register, itself included
    assign wr_ok = reg_wr_in && !ss_reg_q[`SCS_LOCK_BIT] && load_done_out;

    always @(posedge clk_in) begin
        if (!reset_n_in) begin
            ss_reg_q      <= `SCS_REG_RESET;
            fault_reg_q   <= `SCS_REG_RESET;
            restart_reg_q <= `SCS_REG_RESET;
        end else if (ld_state_q == LD_WAIT && ee_valid_in) begin
            case (ld_idx_q)
                2'h0:    ss_reg_q      <= ee_data_in;
                2'h1:    fault_reg_q   <= ee_data_in & ~`SCS_FAULT_RSVD_MASK;
                default: restart_reg_q <= ee_data_in;
            endcase
        end else if (wr_ok) begin
            case (reg_addr_in)
                `SCS_OFS_SOFTSTART: ss_reg_q    <= reg_wdata_in;
                `SCS_OFS_FAULT:     fault_reg_q <= reg_wdata_in & ~`SCS_FAULT_RSVD_MASK;
                `SCS_OFS_RESTART:   restart_reg_q <= reg_wdata_in;
                default:            ss_reg_q    <= ss_reg_q;
            endcase
        end
    end

    // Read port; drive bit reads as zero
    always @(posedge clk_in) begin
        if (!reset_n_in) begin
            reg_rdata_out <= 8'h00;
            reg_ack_out   <= 1'b0;
        end else begin
            reg_ack_out <= reg_rd_in | reg_wr_in;
            if (reg_rd_in) begin
                case (reg_addr_in)
                    `SCS_OFS_SOFTSTART: reg_rdata_out <= ss_reg_q;
                    `SCS_OFS_FAULT:     reg_rdata_out <= fault_reg_q;
                    `SCS_OFS_RESTART:   reg_rdata_out <= restart_reg_q & `SCS_RESTART_RD_MASK;
                    default:            reg_rdata_out <= 8'h00;
                endcase
            end
        end
    end

    // Soft-start rise time in microsecond ticks
    assign ss_ticks = (ss_reg_q[`SCS_SSRATE_HI:`SCS_SSRATE_LO] == 2'h0) ? SS_T0_TICKS[19:0] :
                      (ss_reg_q[`SCS_SSRATE_HI:`SCS_SSRATE_LO] == 2'h1) ? SS_T1_TICKS[19:0] :
                      (ss_reg_q[`SCS_SSRATE_HI:`SCS_SSRATE_LO] == 2'h2) ? SS_T2_TICKS[19:0] :
                                                                          SS_T3_TICKS[19:0];

    // Overcurrent ridethrough qualification
    assign rt_ticks = fault_reg_q[`SCS_ZERO_RT] ? RT_RESID_TICKS[19:0] :
                      (({18'h00000, ridethrough_sel_in} + 20'h00001) * RT_STEP_TICKS[19:0]);

    always @(posedge clk_in) begin
        if (!reset_n_in) begin
            rt_cnt_q <= 20'h00000;
        end else if (!oc_s) begin
            rt_cnt_q <= 20'h00000;
        end else if (us_tick && rt_cnt_q < rt_ticks) begin
            rt_cnt_q <= rt_cnt_q + 20'h00001;
        end
    end

    assign oc_eff = oc_s && (rt_cnt_q >= rt_ticks) && !fault_reg_q[`SCS_CURR_LIM_DIS];
    assign fault  = oc_eff || uv_s;
    assign pm_ok  = fault_reg_q[`SCS_GND_DIS] || gnd_s;

    // Power sequencing
    always @* begin
        st_d = st_q;
        case (st_q)
            ST_OFF: begin
                if (son_s && pm_ok && load_done_out) begin
                    st_d = ST_SOFT;
                end
            end
            ST_SOFT, ST_ON: begin
                if (!son_s || !pm_ok) begin
                    st_d = ST_OFF;
                end else if (fault && restart_reg_q[`SCS_RESTART_MODE]) begin
                    st_d = ST_RETRY;
                end else if (fault) begin
                    st_d = ST_LATCH;
                end else if (st_q == ST_SOFT && us_tick && tmr_q >= ss_ticks - 20'h00001) begin
                    st_d = ST_ON;
                end
            end
            ST_LATCH: begin
                if (!son_s) begin
                    st_d = ST_OFF;
                end
            end
            ST_RETRY: begin
                if (!son_s) begin
                    st_d = ST_OFF;
                end else if (us_tick && tmr_q >= RETRY_TICKS[19:0] - 20'h00001) begin
                    st_d = ST_SOFT;
                end
            end
            default: st_d = ST_OFF;
        endcase
    end

    always @(posedge clk_in) begin
        if (!reset_n_in) begin
            st_q  <= ST_OFF;
            tmr_q <= 20'h00000;
        end else begin
            st_q <= st_d;
            if (st_d != st_q) begin
                tmr_q <= 20'h00000;
            end else if (us_tick) begin
                tmr_q <= tmr_q + 20'h00001;
            end
        end
    end

    // Breaker: follows fault, or holds until cleared
    assign brk_raw = fault || (st_q == ST_LATCH);
    always @(posedge clk_in) begin
        if (!reset_n_in) begin
            brk_hold_q <= 1'b0;
        end else if (brk_raw && fault_reg_q[`SCS_BRK_LATCH]) begin
            brk_hold_q <= 1'b1;
        end else if (breaker_clear_in || !fault_reg_q[`SCS_BRK_LATCH]) begin
            brk_hold_q <= 1'b0;
        end
    end

    assign pen_inv = fault_reg_q[`SCS_PEN_POL_LO] ^ power_enable_pol_hi_in;
    assign brk_inv = fault_reg_q[`SCS_BRK_POL_LO] ^ breaker_pol_hi_in;

    // Registered outputs
    always @(posedge clk_in) begin
        if (!reset_n_in) begin
            share_capture_pct_out <= 3'h1;
            second_addr_bit_out   <= 1'b0;
            trim_lock_out         <= 1'b0;
            soft_start_active_out <= 1'b0;
            power_enable_out      <= 1'b0;
            breaker_out           <= 1'b0;
            oc_flag_out           <= 1'b0;
            fault_latched_out     <= 1'b0;
            ac_sense_ok_out       <= 1'b0;
        end else begin
            share_capture_pct_out <= {1'b0, ss_reg_q[`SCS_SHARE_HI:`SCS_SHARE_LO]} + 3'h1;
            second_addr_bit_out   <= ss_reg_q[`SCS_ADDR_BIT];
            trim_lock_out         <= ss_reg_q[`SCS_LOCK_BIT];
            soft_start_active_out <= (st_q == ST_SOFT);
            power_enable_out      <= ((st_q == ST_SOFT) || (st_q == ST_ON)) ^ pen_inv;
            breaker_out           <= (fault_reg_q[`SCS_BRK_LATCH] ? (brk_hold_q || brk_raw)
                                                                  : brk_raw) ^ brk_inv;
            oc_flag_out           <= oc_s;
            fault_latched_out     <= (st_q == ST_LATCH);
            ac_sense_ok_out       <= restart_reg_q[`SCS_AC_GATE_MODE] ?
                                     restart_reg_q[`SCS_AC_DRIVE] : ac_s;
        end
    end
endmodule // scs_config_regs

// ===== scs_defines.vh
// Constants of the supply configuration register group.
// Assumes inclusion by bare name from the design files.
`ifndef SCS_DEFINES_VH
`define SCS_DEFINES_VH

// Register offsets
`define SCS_OFS_SOFTSTART      8'h10
`define SCS_OFS_FAULT          8'h11
`define SCS_OFS_RESTART        8'h12

// EEPROM shadow locations
`define SCS_EE_SOFTSTART       16'h8110
`define SCS_EE_FAULT           16'h8111
`define SCS_EE_RESTART         16'h8112

// Soft-start/share config fields
`define SCS_SHARE_HI           5
`define SCS_SHARE_LO           4
`define SCS_SSRATE_HI          3
`define SCS_SSRATE_LO          2
`define SCS_ADDR_BIT           1
`define SCS_LOCK_BIT           0

// Fault/polarity config fields
`define SCS_CURR_LIM_DIS       7
`define SCS_PEN_POL_LO         6
`define SCS_BRK_POL_LO         5
`define SCS_FAULT_RSVD_MASK    8'h18
`define SCS_ZERO_RT            2
`define SCS_GND_DIS            1
`define SCS_BRK_LATCH          0

// Restart/AC-sense config fields
`define SCS_RESTART_MODE       7
`define SCS_AC_GATE_MODE       6
`define SCS_AC_DRIVE           5
`define SCS_RESTART_RD_MASK    8'hDF

// Reset value before the EEPROM copy arrives
`define SCS_REG_RESET          8'h00

// Timing figures in their own units
`define SCS_CLK_MHZ            100
`define SCS_SS_T0_US           300
`define SCS_SS_T1_MS           10
`define SCS_SS_T2_MS           20
`define SCS_SS_T3_MS           40
`define SCS_RETRY_S            1
`define SCS_RT_STEP_US         128
`define SCS_RT_RESID_US        1

// Derived counts
`define SCS_US_CYCLES          (`SCS_CLK_MHZ)
`define SCS_SS_T0_TICKS        (`SCS_SS_T0_US)
`define SCS_SS_T1_TICKS        (`SCS_SS_T1_MS * 1000)
`define SCS_SS_T2_TICKS        (`SCS_SS_T2_MS * 1000)
`define SCS_SS_T3_TICKS        (`SCS_SS_T3_MS * 1000)
`define SCS_RETRY_TICKS        (`SCS_RETRY_S * 1000000)

`endif

// ===== scs_tick_div.v
// One-cycle enable pulse every DIV clock cycles.
// Assumes a single clock and synchronous active-low reset.
`timescale 1ns/100ps
module scs_tick_div #(
    parameter DIV = 100
) (
    input  wire clk_in,         // System clock
    input  wire reset_n_in,     // Synchronous reset, active low
    output reg  tick_out        // One-cycle pulse
);
    reg [15:0] cnt_q;

    always @(posedge clk_in) begin
        if (!reset_n_in) begin
            cnt_q    <= 16'h0000;
            tick_out <= 1'b0;
        end else if (cnt_q == DIV[15:0] - 16'h0001) begin
            cnt_q    <= 16'h0000;
            tick_out <= 1'b1;
        end else begin
            cnt_q    <= cnt_q + 16'h0001;
            tick_out <= 1'b0;
        end
    end
endmodule // scs_tick_div

// ===== scs_config_checker.sv
// Assertion checker for the supply configuration register group.
// Bound to scs_config_regs; sees its ports only.
`timescale 1ns/100ps
module scs_config_checker (
    input wire        clk_in,                // Clock
    input wire        reset_n_in,            // Reset, active low
    input wire        reg_wr_in,             // Write strobe
    input wire        reg_rd_in,             // Read strobe
    input wire [7:0]  reg_addr_in,           // Offset
    input wire [7:0]  reg_rdata_out,         // Read data
    input wire        reg_ack_out,           // Access done
    input wire        ee_rd_req_out,         // EEPROM request
    input wire [15:0] ee_addr_out,           // EEPROM location
    input wire        ee_valid_in,           // EEPROM valid
    input wire        load_done_out,         // Load complete
    input wire        supply_on_req_in,      // Supply-on pin
    input wire        overcurrent_in,        // Overcurrent pin
    input wire [2:0]  share_capture_pct_out, // Share threshold
    input wire        second_addr_bit_out,   // Address bit
    input wire        soft_start_active_out, // Soft-start running
    input wire        oc_flag_out,           // Overcurrent flag
    input wire        fault_latched_out      // Latched off
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);

    sequence s_rd_ss;
        reg_rd_in && reg_addr_in == 8'h10 && load_done_out && !$past(reg_wr_in);
    endsequence
    sequence s_ee_got(a);
        ee_valid_in && ee_addr_out == a && !load_done_out;
    endsequence
    sequence s_ss_start;
        $rose(soft_start_active_out);
    endsequence

    a_ack_one_cycle: assert property (
        reg_ack_out == $past(reg_wr_in || reg_rd_in)) else $error("ack not one cycle after strobe");
    a_share_addr_bit: assert property (
        s_rd_ss |=> share_capture_pct_out == {1'b0, reg_rdata_out[5:4]} + 3'h1
        && second_addr_bit_out == reg_rdata_out[1]) else $error("share or address bit wrong");
    a_first_ee_req: assert property (
        $rose(reset_n_in) |-> ##1 (ee_rd_req_out && ee_addr_out == 16'h8110))
        else $error("first EEPROM request wrong");
    a_ee_second_req: assert property (
        s_ee_got(16'h8110) |-> ##2 (ee_rd_req_out && ee_addr_out == 16'h8111))
        else $error("second EEPROM request wrong");
    a_ee_third_req: assert property (
        s_ee_got(16'h8111) |-> ##2 (ee_rd_req_out && ee_addr_out == 16'h8112))
        else $error("third EEPROM request wrong");
    a_load_done_set: assert property (
        s_ee_got(16'h8112) |=> load_done_out) else $error("load done late");
    a_oc_flag_follows: assert property (
        $stable(overcurrent_in)[*4] |-> oc_flag_out == overcurrent_in)
        else $error("overcurrent flag wrong");
    a_ss_min_len: assert property (
        s_ss_start |-> soft_start_active_out[*4]) else $error("soft-start too short");
    a_ss_max_len: assert property (
        s_ss_start |-> ##[1:1000] !soft_start_active_out) else $error("soft-start too long");
    a_latch_holds: assert property (
        fault_latched_out && supply_on_req_in && $past(supply_on_req_in)
        && $past(supply_on_req_in, 2) && $past(supply_on_req_in, 3)
        |=> fault_latched_out) else $error("latch cleared early");
    a_off_no_start: assert property (
        (!supply_on_req_in)[*5] |-> !soft_start_active_out) else $error("start without request");
endmodule // scs_config_checker

// ===== scs_ee_model.sv
// EEPROM shadow reader model answering one byte per request.
// Assumes requests from scs_config_regs on the same clock.
`timescale 1ns/100ps
module scs_ee_model (
    input  wire        clk_in,       // Clock
    input  wire        ee_rd_req_in, // Read request pulse
    input  wire [15:0] ee_addr_in,   // Location
    input  wire [23:0] image_in,     // Bytes at 8112..8110
    input  wire [3:0]  delay_in,     // Answer delay, cycles
    output reg         ee_valid_out, // Data valid pulse
    output reg  [7:0]  ee_data_out   // Data byte
);
    integer   cnt = -1;
    reg [1:0] idx_q = 2'h0;
    initial begin
        ee_valid_out = 1'b0;
        ee_data_out = 8'hA5;
    end
    always @(posedge clk_in) begin
        ee_valid_out <= 1'b0;
        // Idle data toggles so stale bytes are never seen
        ee_data_out <= ~ee_data_out;
        if (ee_rd_req_in) begin
            cnt <= delay_in;
            idx_q <= ee_addr_in[1:0];
        end else if (cnt == 0) begin
            ee_valid_out <= 1'b1;
            ee_data_out <= image_in[8*idx_q +: 8];
            cnt <= -1;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
        end
    end
endmodule // scs_ee_model

// ===== scs_config_regs_tb.sv
// Self-checking bench for scs_config_regs with an EEPROM model.
// Assumes the design files, checker and scs_ee_model compile first.
`timescale 1ns/100ps
`define CHK(g, e) begin cmp_count = cmp_count + 1; if ((g) !== (e)) begin \
    mismatches = mismatches + 1; $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end
`define WAIT(c, lim) begin n = 0; while (!(c) && n < lim) begin @(negedge clk_in); \
    n = n + 1; end if (!(c)) begin mismatches = mismatches + 1; test_done; end end
module scs_config_regs_tb;
    reg         clk_in = 1'b0, reset_n_in = 1'b0, reg_wr_in = 1'b0, reg_rd_in = 1'b0;
    reg  [7:0]  reg_addr_in = 8'h00, reg_wdata_in = 8'h00, a, v, d;
    reg         test_download_in = 1'b0, supply_on_req_in = 1'b0, ac_ok_raw_in = 1'b0;
    reg         gnd_ok_in = 1'b0, overcurrent_in = 1'b0, pen_ph = 1'b0, brk_ph = 1'b0;
    reg  [23:0] image = 24'h000000;
    reg  [3:0]  ee_delay = 4'h0;
    reg  [1:0]  rt_sel = 2'b00;
    reg         uv = 1'b0, brk_clr = 1'b0;
    reg  [7:0]  exp_q [0:2];
    wire [7:0]  reg_rdata_out, ee_data_in;
    wire [15:0] ee_addr_out;
    wire [2:0]  share_capture_pct_out;
    wire        reg_ack_out, ee_rd_req_out, ee_valid_in, load_done_out, second_addr_bit_out;
    wire        trim_lock_out, soft_start_active_out, power_enable_out, breaker_out;
    wire        oc_flag_out, fault_latched_out, ac_sense_ok_out;
    integer     mismatches = 0, cmp_count = 0, i, n;

    always #5 clk_in = ~clk_in;

    scs_config_regs #(.SS_T0_TICKS(3), .SS_T1_TICKS(5), .SS_T2_TICKS(7),
        .SS_T3_TICKS(9), .RETRY_TICKS(8)) u_dut (
        .clk_in, .reset_n_in, .reg_wr_in, .reg_rd_in, .reg_addr_in, .reg_wdata_in,
        .reg_rdata_out, .reg_ack_out, .ee_rd_req_out, .ee_addr_out, .ee_valid_in, .ee_data_in,
        .test_download_in, .load_done_out, .supply_on_req_in, .ac_ok_raw_in, .gnd_ok_in,
        .overcurrent_in, .undervoltage_in(uv), .power_enable_pol_hi_in(pen_ph),
        .breaker_pol_hi_in(brk_ph), .ridethrough_sel_in(rt_sel), .breaker_clear_in(brk_clr),
        .share_capture_pct_out, .second_addr_bit_out, .trim_lock_out, .soft_start_active_out,
        .power_enable_out, .breaker_out, .oc_flag_out, .fault_latched_out, .ac_sense_ok_out);

    scs_ee_model u_ee (.clk_in, .ee_rd_req_in(ee_rd_req_out), .ee_addr_in(ee_addr_out),
        .image_in(image), .delay_in(ee_delay), .ee_valid_out(ee_valid_in),
        .ee_data_out(ee_data_in));

    function [7:0] fexp(input [7:0] ad);
        fexp = (ad == 8'h10) ? exp_q[0] : (ad == 8'h11) ? exp_q[1] & 8'hE7 :
               (ad == 8'h12) ? exp_q[2] & 8'hDF : 8'h00;
    endfunction
    function integer fss(input integer code);
        fss = (3 + 2 * code) * 100;
    endfunction

    task test_done;
        begin
            $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
            if (mismatches == 0 && cmp_count > 0) $display("SIMULATION PASSED");
            else $display("SIMULATION FAILED");
            $finish;
        end
    endtask
    task acc(input wr, input [7:0] ad, input [7:0] wd);
        begin
            @(negedge clk_in);
            reg_wr_in = wr;
            reg_rd_in = !wr;
            reg_addr_in = ad;
            reg_wdata_in = wd;
            @(negedge clk_in);
            reg_wr_in = 1'b0;
            reg_rd_in = 1'b0;
            `CHK(reg_ack_out, 1'b1)
            d = reg_rdata_out;
        end
    endtask
    task wr(input [7:0] ad, input [7:0] wd);
        begin
            acc(1'b1, ad, wd);
            if (ad >= 8'h10 && ad <= 8'h12 && !exp_q[0][0]) exp_q[ad[1:0]] = wd;
        end
    endtask
    task rdchk(input [7:0] ad);
        begin
            acc(1'b0, ad, 8'h00);
            `CHK(d, fexp(ad))
        end
    endtask
    task load_exp;
        begin
            exp_q[0] = image[7:0];
            exp_q[1] = image[15:8];
            exp_q[2] = image[23:16];
        end
    endtask

    initial begin
        n = $urandom(69);
        image = $urandom & 24'hFFFFFE;
        ee_delay = $urandom % 4;
        rt_sel = $urandom % 4;
        repeat (2) @(negedge clk_in);
        `CHK(share_capture_pct_out, 3'h1)
        reset_n_in = 1'b1;
        load_exp;
        `WAIT(load_done_out, 100)
        for (i = 0; i < 4; i = i + 1) rdchk(8'h10 + i[7:0]);
        `CHK(share_capture_pct_out, {1'b0, image[5:4]} + 3'h1)
        `CHK(second_addr_bit_out, image[1])
        for (i = 0; i < 4; i = i + 1) begin
            wr(8'h10, {2'b00, i[1:0], 4'h0});
            @(negedge clk_in);
            `CHK(share_capture_pct_out, {1'b0, i[1:0]} + 3'h1)
        end
        for (i = 0; i < 12; i = i + 1) begin
            a = 8'h10 + $urandom % 4;
            v = $urandom & ((a == 8'h10) ? 8'hFE : 8'hFF);
            wr(a, v);
            rdchk(a);
        end
        for (i = 0; i < 4; i = i + 1) begin
            ac_ok_raw_in = $urandom;
            wr(8'h12, {1'b0, i[1], i[0], 5'h00});
            repeat (4) @(negedge clk_in);
            `CHK(ac_sense_ok_out, i[1] ? i[0] : ac_ok_raw_in)
        end
        gnd_ok_in = 1'b1;
        wr(8'h11, 8'h04);
        for (i = 0; i < 5; i = i + 1) begin
            wr(8'h10, {4'h0, i[1:0], 2'b00});
            supply_on_req_in = 1'b1;
            `WAIT(soft_start_active_out, 10)
            `WAIT(!soft_start_active_out, 1000)
            `CHK(n >= fss(i % 4) - 100 && n <= fss(i % 4) + 4, 1'b1)
            if (i < 4) supply_on_req_in = 1'b0;
            repeat (6) @(negedge clk_in);
        end
        for (i = 0; i < 4; i = i + 1) begin
            pen_ph = $urandom;
            brk_ph = $urandom;
            wr(8'h11, {1'b0, i[0], i[1], 5'h04});
            repeat (2) @(negedge clk_in);
            `CHK(power_enable_out, ~(i[0] ^ pen_ph))
            `CHK(breaker_out, i[1] ^ brk_ph)
        end
        pen_ph = 1'b0;
        brk_ph = 1'b0;
        wr(8'h11, 8'h84);
        overcurrent_in = 1'b1;
        repeat (20) @(negedge clk_in);
        `CHK(oc_flag_out, 1'b1)
        `CHK(fault_latched_out, 1'b0)
        wr(8'h11, 8'h07);
        `WAIT(fault_latched_out, 200)
        overcurrent_in = 1'b0;
        repeat (20) @(negedge clk_in);
        `CHK(fault_latched_out, 1'b1)
        `CHK(power_enable_out, 1'b0)
        supply_on_req_in = 1'b0;
        repeat (6) @(negedge clk_in);
        `CHK(fault_latched_out, 1'b0)
        `CHK(breaker_out, 1'b1)
        brk_clr = 1'b1;
        @(negedge clk_in);
        brk_clr = 1'b0;
        repeat (2) @(negedge clk_in);
        `CHK(breaker_out, 1'b0)
        gnd_ok_in = 1'b0;
        wr(8'h12, 8'h80);
        supply_on_req_in = 1'b1;
        `WAIT(soft_start_active_out, 10)
        `WAIT(!soft_start_active_out, 1000)
        uv = 1'b1;
        `WAIT(!power_enable_out, 20)
        uv = 1'b0;
        `CHK(fault_latched_out, 1'b0)
        `WAIT(soft_start_active_out, 1000)
        supply_on_req_in = 1'b0;
        wr(8'h10, 8'h01);
        wr(8'h11, 8'hFF);
        wr(8'h10, 8'h00);
        rdchk(8'h11);
        rdchk(8'h10);
        `CHK(trim_lock_out, 1'b1)
        image = $urandom & 24'hFFFFFE;
        load_exp;
        @(negedge clk_in);
        test_download_in = 1'b1;
        @(negedge clk_in);
        test_download_in = 1'b0;
        `WAIT(!trim_lock_out && load_done_out, 60)
        for (i = 0; i < 3; i = i + 1) rdchk(8'h10 + i[7:0]);
        test_done;
    end
endmodule // scs_config_regs_tb

bind scs_config_regs scs_config_checker u_chk (.*);
